// *** bench/pmb_properties.sv ***
// Checks on the link between the master core and the far end.
// Assumes one PCI clock and presetn as asynchronous active-low reset.
`timescale 1ns/10ps
module pmb_properties (
   input logic pclk,
   input logic presetn,
   input logic req_n,
   input logic gnt_n,
   input logic frame_n,
   input logic frame_oe,
   input logic irdy_n,
   input logic irdy_oe,
   input logic ad_oe,
   input logic par_oe,
   input logic trdy_n,
   input logic devsel_n,
   input logic local_request_narrow_n,
   input logic local_request_wide_n,
   input logic local_grant_n,
   input logic [3:0] local_master_phase,
   input logic [1:0] local_end_cause,
   input logic [pmb_pkg::BURST_W-1:0] burst_remaining_count,
   input logic [pmb_pkg::BURST_W-1:0] burst_length_in,
   input logic local_word_taken_n,
   input logic local_low_word_taken_n,
   input logic local_high_word_taken_n
);
   logic in_idle;
   logic in_trans;
   logic in_term;
   logic done;
   assign in_idle = local_master_phase == pmb_pkg::PH_IDLE;
   assign in_trans = local_master_phase == pmb_pkg::PH_TRANS;
   assign in_term = local_master_phase == pmb_pkg::PH_TERM;
   assign done = !irdy_n && !trdy_n;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ///////////////////////////////////////////////////////////////////////
   a_req_on_request: assert property (
      $fell(local_request_wide_n && local_request_narrow_n) |=> !req_n)
      else $error("REQ# not raised after local request");
   a_grant_on_gnt: assert property (
      (!gnt_n && !req_n && frame_n && irdy_n && in_idle) |=> !local_grant_n)
      else $error("local grant missing");
   a_addr_phase: assert property (
      (local_master_phase == pmb_pkg::PH_ALOAD && !gnt_n) |=> (!frame_n
      && ad_oe && in_trans && burst_remaining_count == burst_length_in))
      else $error("address phase wrong");
   a_count_step: assert property (
      (in_trans && done) |=>
      burst_remaining_count == $past(burst_remaining_count) - 1'b1)
      else $error("burst count not decremented");
   a_last_strobe: assert property (
      (in_trans && frame_n && !irdy_n) |-> local_word_taken_n)
      else $error("strobe in last phase");
   a_turn_around: assert property (
      (in_trans && frame_n && done) |=> (!frame_oe && !ad_oe && irdy_oe
      && irdy_n && burst_remaining_count == '0 && in_term
      && local_end_cause == pmb_pkg::END_NORMAL))
      else $error("turnaround wrong");
   a_target_release: assert property (
      (frame_n && done) |=> (trdy_n && devsel_n))
      else $error("target not released");
   a_idle_release: assert property (
      in_term |=> (!in_idle || (!irdy_oe && !par_oe)))
      else $error("IRDY# or PAR still driven");
   a_wide_pair: assert property (
      (local_low_word_taken_n == local_high_word_taken_n) &&
      (local_low_word_taken_n || !local_request_wide_n))
      else $error("wide strobes split");
   a_b2b_hold: assert property (
      (!frame_n && !local_request_wide_n && in_trans) |=> !req_n)
      else $error("REQ# dropped with wide request");
   c_chain: cover property (in_term ##1 !in_idle);
   c_last: cover property (in_trans && frame_n && done);
   c_wide: cover property (!local_low_word_taken_n);
endmodule : pmb_properties

// *** bench/test_pci_master_burst_back_to_back.sv ***
// Self-checking bench: core and far end joined, runs ordered over APB.
// Assumes the far end answers APB and acts as arbiter and target.
`timescale 1ns/10ps
module test_pci_master_burst_back_to_back;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_r;
   logic prev_frame;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   integer seed, errors, compares, frames, phases, strobes, gaps, exp_txn;
   integer i;
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   pmb_if u_pmb_if (.pclk(pclk));
   pmb_core u_pmb_core (.pclk(pclk), .presetn(presetn), .bus_owner(),
      .bus(u_pmb_if));
   pmb_far u_pmb_far (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(u_pmb_if));
   pmb_properties u_pmb_properties (.pclk(pclk), .presetn(presetn),
      .req_n(u_pmb_if.req_n), .gnt_n(u_pmb_if.gnt_n),
      .frame_n(u_pmb_if.frame_n), .frame_oe(u_pmb_if.frame_oe),
      .irdy_n(u_pmb_if.irdy_n), .irdy_oe(u_pmb_if.irdy_oe),
      .ad_oe(u_pmb_if.ad_oe), .par_oe(u_pmb_if.par_oe),
      .trdy_n(u_pmb_if.trdy_n), .devsel_n(u_pmb_if.devsel_n),
      .local_request_narrow_n(u_pmb_if.local_request_narrow_n),
      .local_request_wide_n(u_pmb_if.local_request_wide_n),
      .local_grant_n(u_pmb_if.local_grant_n),
      .local_master_phase(u_pmb_if.local_master_phase),
      .local_end_cause(u_pmb_if.local_end_cause),
      .burst_remaining_count(u_pmb_if.burst_remaining_count),
      .burst_length_in(u_pmb_if.burst_length_in),
      .local_word_taken_n(u_pmb_if.local_word_taken_n),
      .local_low_word_taken_n(u_pmb_if.local_low_word_taken_n),
      .local_high_word_taken_n(u_pmb_if.local_high_word_taken_n));
   ///////////////////////////////////////////////////////////////////////
   // Wire monitor: frame starts, completed phases, strobes, idle gaps
   always @(posedge pclk) begin
      prev_frame <= u_pmb_if.frame_n;
      if (prev_frame === 1'b1 && u_pmb_if.frame_n === 1'b0) begin
         frames <= frames + 1;
      end
      if (u_pmb_if.irdy_n === 1'b0 && u_pmb_if.trdy_n === 1'b0) begin
         phases <= phases + 1;
      end
      if (u_pmb_if.local_word_taken_n === 1'b0 ||
         u_pmb_if.local_low_word_taken_n === 1'b0) begin
         strobes <= strobes + 1;
      end
      if (frames > 0 && frames < exp_txn &&
         u_pmb_if.local_master_phase === pmb_pkg::PH_IDLE) begin
         gaps <= gaps + 1;
      end
   end
   ///////////////////////////////////////////////////////////////////////
   task report_and_stop;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      integer n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err_r = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         errors++;
         report_and_stop;
      end
   endtask : apb
   task run(input logic wide, input logic [7:0] len, input logic [3:0] txn);
      logic [15:0] base;
      integer n;
      apb(1'b0, pmb_pkg::REG_STAT, 32'h0);
      base = rd[31:16];
      exp_txn = txn;
      frames = 0;
      phases = 0;
      strobes = 0;
      gaps = 0;
      apb(1'b1, pmb_pkg::REG_ADDR, $random(seed) & 32'hFFFFFFFC);
      apb(1'b1, pmb_pkg::REG_LEN, {12'h000, pmb_pkg::CMD_RST, 8'h00, len});
      apb(1'b1, pmb_pkg::REG_DLO, $random(seed));
      apb(1'b1, pmb_pkg::REG_DHI, $random(seed));
      apb(1'b1, pmb_pkg::REG_CTRL, {24'h0, txn, 2'b00, wide, 1'b1});
      n = 0;
      do begin
         apb(1'b0, pmb_pkg::REG_STAT, 32'h0);
         n++;
      end while (rd[pmb_pkg::STAT_BUSY] !== 1'b0 && n < 300);
      if (n >= 300) begin
         errors++;
         report_and_stop;
      end
      chk(rd[3:0], pmb_pkg::PH_IDLE);
      chk(rd[5:4], pmb_pkg::END_NORMAL);
      chk(16'(rd[31:16] - base), 16'(len * txn));
      chk(frames, txn);
      chk(gaps, 0);
      chk(phases, len * txn);
      chk(strobes, len * txn);
      $display("test done: wide %0d len %0d txn %0d", wide, len, txn);
   endtask : run
   ///////////////////////////////////////////////////////////////////////
   initial begin
      seed = 97;
      errors = 0;
      compares = 0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {frames, phases, strobes, gaps, exp_txn} = '0;
      prev_frame = 1'b1;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, pmb_pkg::REG_STAT, 32'h0);
      chk(rd[8:0], 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk(err_r, 32'h1);
      apb(1'b1, 8'h03, 32'hFFFFFFFF);
      chk(err_r, 32'h1);
      $display("test done: reset and unmapped access");
      run(1'b1, 8'h01, 4'h1);
      run(1'b0, 8'h01, 4'h3);
      run(1'b1, 8'h04, 4'h3);
      for (i = 0; i < 6; i++) begin
         run(1'($random(seed)), 8'(1 + $unsigned($random(seed)) % 8),
            4'(1 + $unsigned($random(seed)) % 3));
      end
      report_and_stop;
   end
endmodule : test_pci_master_burst_back_to_back

// *** core/pmb_core.sv ***
// PCI master core: burst write ending and fast back-to-back start.
// Assumes the far end drives arbiter, target and local master signals.
// Contract
// (R1) Decrement burst counter after each completed phase
// (R2) Next word onto AD after acceptance
// (R3) Last phase: FRAME# off, single strobe off
// (R4) Phase completes only with IRDY# and TRDY#
// (R5) Turnaround: release lines, count zero, terminate
// (R6) Normal end cause when last phase completed
// (R7) Target drops DEVSEL#, TRDY# at turnaround
// (R8) Idle: stop driving IRDY# and PAR
// (R9) Chain requested transactions without idle cycle
// (R10) Request must stand at address loading
// (R11) Local logic holds request until done
// (R12) Back-to-back only after a write
// (R13) Wide request with address, command, length
// (R14) REQ# asserted cycle after local request
// (R15) Local grant on GNT# and idle bus
// (R16) Request and grant: address loading, latch
// (R17) GNT# and loading: FRAME#, REQ64#, address
// (R18) Address phase loads burst counter
// (R19) Wide write: low and high strobes
// (R20) Ready only when data can be supplied
// (R21) Hold REQ# while FRAME# and wide request
// (R22) Strobe means local data being captured
`timescale 1ns/10ps
module pmb_core (
   input wire logic pclk,
   input wire logic presetn,
   output logic bus_owner,
   pmb_if.core bus
);
   typedef enum logic [2:0] {
      S_IDLE, S_ALOAD, S_ADDR, S_DATA, S_TURN
   } pmb_state_t;

   localparam int BW = pmb_pkg::BURST_W;

   pmb_state_t state_r;
   logic req_n_r;
   logic lgnt_n_r;
   logic wide_r;
   logic chain_r;
   logic [3:0] phase_r;
   logic [1:0] cause_r;
   logic [31:0] addr_r;
   logic [3:0] cmd_r;
   logic [BW-1:0] len_r;
   logic [BW-1:0] cnt_r;
   logic [BW-1:0] fetch_r;
   logic [63:0] hold_d_r;
   logic [7:0] hold_be_r;
   logic hold_v_r;
   logic [63:0] ad_r;
   logic [7:0] cbe_r;
   logic bus_v_r;
   logic par_r;
   logic par_oe_r;
   logic lreq;
   logic bus_idle;
   logic complete;
   logic last;
   logic take;
   logic move;
   logic drive;

   ////////////////////////////////////////////////////////////////////
   // Combinational terms
   assign lreq = !bus.local_request_narrow_n || !bus.local_request_wide_n;
   assign bus_idle = bus.frame_n && bus.irdy_n;
   assign drive = (state_r == S_ADDR) || (state_r == S_DATA);
   // (R4) both ready lines
   assign complete = (state_r == S_DATA) && bus_v_r && !bus.trdy_n;
   assign last = (cnt_r == BW'(1));
   // Hold register moves onto AD when AD is free or completing
   assign move = (state_r == S_DATA) && hold_v_r && (!bus_v_r || complete);
   // (R22) strobe when local word is captured
   assign take = drive && (fetch_r != '0) && !bus.local_write_ready_n
      && (!hold_v_r || move);

   assign bus.req_n = req_n_r;
   assign bus.local_grant_n = lgnt_n_r;
   assign bus.local_master_phase = phase_r;
   assign bus.local_end_cause = cause_r;
   assign bus.burst_remaining_count = cnt_r;
   // (R3) final phase with IRDY# on, FRAME# off
   assign bus.frame_n_o = !((state_r == S_ADDR) ||
      ((state_r == S_DATA) && !(bus_v_r && last)));
   assign bus.frame_oe = drive;
   // (R17) REQ64# with FRAME#
   assign bus.req64_n_o = bus.frame_n_o || !wide_r;
   assign bus.irdy_n_o = !((state_r == S_DATA) && bus_v_r);
   // (R5) IRDY# still driven high in turnaround
   assign bus.irdy_oe = drive || (state_r == S_TURN);
   assign bus.ad_o = ad_r;
   assign bus.cbe_o = cbe_r;
   assign bus.ad_oe = drive;
   assign bus.par_o = par_r;
   // (R8) parity released one after turnaround
   assign bus.par_oe = par_oe_r;
   // (R19) wide strobes pair
   assign bus.local_low_word_taken_n = !(take && wide_r);
   assign bus.local_high_word_taken_n = !(take && wide_r);
   // (R3) single strobe per narrow word fetched, off in the last phase
   assign bus.local_word_taken_n = !(take && !wide_r);
   assign bus_owner = drive;

   ////////////////////////////////////////////////////////////////////
   // PCI bus request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_n_r <= 1'b1;
      end else if (!bus.frame_n && drive) begin
         // (R21) keep REQ# for pending chain
         req_n_r <= bus.local_request_wide_n && bus.local_request_narrow_n;
      end else begin
         // (R14) REQ# after local request
         req_n_r <= !lreq;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Local grant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lgnt_n_r <= 1'b1;
      end else begin
         // (R15) grant on GNT# and idle bus
         lgnt_n_r <= !(!bus.gnt_n && lreq &&
            ((state_r == S_IDLE && bus_idle) ||
             (state_r == S_TURN && chain_r)));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transaction sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
         phase_r <= pmb_pkg::PH_IDLE;
         cause_r <= pmb_pkg::END_NONE;
         addr_r <= '0;
         cmd_r <= '0;
         len_r <= '0;
         wide_r <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               // (R16) request and grant seen last cycle
               if (lreq && !lgnt_n_r) begin
                  state_r <= S_ALOAD;
                  phase_r <= pmb_pkg::PH_ALOAD;
                  addr_r <= bus.local_ad_in[31:0];
                  cmd_r <= bus.local_byte_enables_in[3:0];
                  len_r <= bus.burst_length_in;
                  wide_r <= !bus.local_request_wide_n;
               end
            end
            S_ALOAD: begin
               // (R17) start on GNT# seen during loading
               if (!bus.gnt_n) begin
                  state_r <= S_ADDR;
                  phase_r <= pmb_pkg::PH_TRANS;
                  cause_r <= pmb_pkg::END_NONE;
               end else begin
                  state_r <= S_IDLE;
                  phase_r <= pmb_pkg::PH_IDLE;
               end
            end
            S_ADDR: begin
               state_r <= S_DATA;
            end
            S_DATA: begin
               if (complete && last) begin
                  // (R5) turnaround with termination status
                  state_r <= S_TURN;
                  phase_r <= pmb_pkg::PH_TERM;
                  // (R6) both ready lines seen on last phase
                  cause_r <= pmb_pkg::END_NORMAL;
               end
            end
            S_TURN: begin
               // (R9) chained request skips the idle state
               if (chain_r && !bus.gnt_n && lreq) begin
                  state_r <= S_ALOAD;
                  phase_r <= pmb_pkg::PH_ALOAD;
                  addr_r <= bus.local_ad_in[31:0];
                  cmd_r <= bus.local_byte_enables_in[3:0];
                  len_r <= bus.burst_length_in;
                  wide_r <= !bus.local_request_wide_n;
               end else begin
                  state_r <= S_IDLE;
                  phase_r <= pmb_pkg::PH_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
               phase_r <= pmb_pkg::PH_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Fast back-to-back eligibility
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_r <= 1'b0;
      end else if (state_r == S_ALOAD || state_r == S_IDLE) begin
         chain_r <= 1'b0;
      end else if (drive && lreq && cmd_r[0]) begin
         // (R12) only writes (odd command codes) may chain
         chain_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Burst counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         fetch_r <= '0;
      end else begin
         if (state_r == S_ALOAD) begin
            fetch_r <= len_r;
         end else if (take) begin
            fetch_r <= fetch_r - BW'(1);
         end
         if (state_r == S_ALOAD && !bus.gnt_n) begin
            // (R18) count loaded for the address phase
            cnt_r <= len_r;
         end else if (complete && last) begin
            // (R5) counter reaches zero at turnaround
            cnt_r <= '0;
         end else if (complete) begin
            // (R1) one less per completed phase
            cnt_r <= cnt_r - BW'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write data pipeline
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_d_r <= '0;
         hold_be_r <= '0;
         hold_v_r <= 1'b0;
      end else if (take) begin
         hold_d_r <= bus.local_ad_in;
         hold_be_r <= bus.local_byte_enables_in;
         hold_v_r <= 1'b1;
      end else if (move || state_r == S_IDLE) begin
         hold_v_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ad_r <= '0;
         cbe_r <= '0;
         bus_v_r <= 1'b0;
      end else if (state_r == S_ALOAD) begin
         // (R17) address and command for address phase
         ad_r <= {32'h0000_0000, addr_r};
         cbe_r <= {4'h0, cmd_r};
         bus_v_r <= 1'b0;
      end else if (move) begin
         // (R2) next word after target accepted the last
         ad_r <= hold_d_r;
         cbe_r <= hold_be_r;
         bus_v_r <= 1'b1;
      end else if (complete) begin
         bus_v_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Parity, one cycle behind AD
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_r <= 1'b0;
         par_oe_r <= 1'b0;
      end else begin
         par_r <= ^{ad_r[31:0], cbe_r[3:0]};
         par_oe_r <= drive;
      end
   end
endmodule : pmb_core

// *** core/pmb_far.sv ***
// Far end: PCI arbiter, write target and APB-driven local master logic.
// Assumes an APB master on the same clock; zero-wait APB slave.
`timescale 1ns/10ps
module pmb_far (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   pmb_if.far bus
);
   localparam int BW = pmb_pkg::BURST_W;

   logic gnt_n_r;
   logic sel_r;
   logic [31:0] addr_r;
   logic [BW-1:0] len_r;
   logic [3:0] cmd_r;
   logic [31:0] dlo_r;
   logic [31:0] dhi_r;
   logic wide_r;
   logic run_r;
   logic [3:0] txn_r;
   logic [BW-1:0] sent_r;
   logic [15:0] rx_r;
   logic wr;
   logic taken;
   logic loading;
   logic mapped;
   logic last_done;

   assign wr = psel && penable && pwrite;
   assign taken = !bus.local_word_taken_n || !bus.local_low_word_taken_n;
   assign loading = bus.local_master_phase != pmb_pkg::PH_TRANS;
   assign mapped = paddr <= pmb_pkg::REG_STAT && paddr[1:0] == 2'b00;
   assign last_done = sel_r && bus.frame_n && !bus.irdy_n;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   ////////////////////////////////////////////////////////////////////
   // Arbiter and target
   assign bus.gnt_n = gnt_n_r;
   assign bus.devsel_n = !sel_r;
   assign bus.trdy_n = !sel_r;
   assign bus.ack64_n = !(sel_r && !bus.req64_n);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gnt_n_r <= 1'b1;
         sel_r <= 1'b0;
         rx_r <= '0;
      end else begin
         gnt_n_r <= bus.req_n;
         if (!bus.frame_n && !sel_r) begin
            sel_r <= 1'b1;
         end else if (sel_r && bus.frame_n && !bus.irdy_n) begin
            // (R7) release in turnaround after last phase
            sel_r <= 1'b0;
         end
         if (sel_r && !bus.irdy_n) begin
            rx_r <= rx_r + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Local master request and data
   // (R10) (R13) request with address, command, length together
   assign bus.local_request_narrow_n = !(run_r && !wide_r);
   assign bus.local_request_wide_n = !(run_r && wide_r);
   assign bus.burst_length_in = len_r;
   assign bus.local_ad_in = loading ? {32'h0000_0000, addr_r} :
      {dhi_r + 32'(sent_r), dlo_r + 32'(sent_r)};
   assign bus.local_byte_enables_in = loading ? {4'h0, cmd_r} : 8'h00;
   // (R20) ready only while words remain
   assign bus.local_write_ready_n = !(run_r && !loading && sent_r < len_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
         txn_r <= '0;
         sent_r <= '0;
      end else if (wr && paddr == pmb_pkg::REG_CTRL
         && pwdata[pmb_pkg::CTRL_GO] && !run_r) begin
         run_r <= 1'b1;
         txn_r <= pwdata[pmb_pkg::CTRL_TXN_LSB +: 4];
         sent_r <= '0;
      end else if (bus.local_master_phase == pmb_pkg::PH_TERM) begin
         sent_r <= '0;
         txn_r <= txn_r - 4'h1;
      end else begin
         if (taken) begin
            sent_r <= sent_r + BW'(1);
         end
         // (R11) drop request as the last phase of the last run completes
         if (last_done && txn_r <= 4'h1) begin
            run_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r <= '0;
         len_r <= BW'(1);
         cmd_r <= pmb_pkg::CMD_RST;
         dlo_r <= '0;
         dhi_r <= '0;
         wide_r <= 1'b0;
      end else if (wr) begin
         case (paddr)
            pmb_pkg::REG_CTRL: begin
               if (!run_r) begin
                  wide_r <= pwdata[pmb_pkg::CTRL_WIDE];
               end
            end
            pmb_pkg::REG_ADDR: begin
               addr_r <= pwdata;
            end
            pmb_pkg::REG_LEN: begin
               len_r <= pwdata[BW-1:0];
               cmd_r <= pwdata[pmb_pkg::LEN_CMD_LSB +: 4];
            end
            pmb_pkg::REG_DLO: begin
               dlo_r <= pwdata;
            end
            pmb_pkg::REG_DHI: begin
               dhi_r <= pwdata;
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         pmb_pkg::REG_CTRL: begin
            prdata[pmb_pkg::CTRL_WIDE] = wide_r;
            prdata[pmb_pkg::CTRL_TXN_LSB +: 4] = txn_r;
         end
         pmb_pkg::REG_ADDR: prdata = addr_r;
         pmb_pkg::REG_LEN: begin
            prdata[BW-1:0] = len_r;
            prdata[pmb_pkg::LEN_CMD_LSB +: 4] = cmd_r;
         end
         pmb_pkg::REG_DLO: prdata = dlo_r;
         pmb_pkg::REG_DHI: prdata = dhi_r;
         pmb_pkg::REG_STAT: begin
            prdata[3:0] = bus.local_master_phase;
            prdata[pmb_pkg::STAT_CAUSE_LSB +: 2] = bus.local_end_cause;
            prdata[pmb_pkg::STAT_BUSY] = run_r ||
               bus.local_master_phase != pmb_pkg::PH_IDLE;
            prdata[pmb_pkg::STAT_RX_LSB +: 16] = rx_r;
         end
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule : pmb_far

// *** core/pmb_if.sv ***
// Interface joining the master core to the PCI bus and local logic.
// Assumes pull-ups on shared PCI lines when nobody drives them.
`timescale 1ns/10ps
interface pmb_if (
   input logic pclk
);
   logic req_n;
   logic gnt_n;
   logic frame_n_o;
   logic frame_oe;
   logic req64_n_o;
   logic irdy_n_o;
   logic irdy_oe;
   logic [63:0] ad_o;
   logic ad_oe;
   logic [7:0] cbe_o;
   logic par_o;
   logic par_oe;
   logic trdy_n;
   logic devsel_n;
   logic ack64_n;
   logic frame_n;
   logic irdy_n;
   logic req64_n;
   logic local_request_narrow_n;
   logic local_request_wide_n;
   logic local_grant_n;
   logic [3:0] local_master_phase;
   logic [1:0] local_end_cause;
   logic [pmb_pkg::BURST_W-1:0] burst_remaining_count;
   logic [pmb_pkg::BURST_W-1:0] burst_length_in;
   logic local_write_ready_n;
   logic local_word_taken_n;
   logic local_low_word_taken_n;
   logic local_high_word_taken_n;
   logic [7:0] local_byte_enables_in;
   logic [63:0] local_ad_in;

   // Resolved shared lines
   assign frame_n = frame_oe ? frame_n_o : 1'b1;
   assign req64_n = frame_oe ? req64_n_o : 1'b1;
   assign irdy_n = irdy_oe ? irdy_n_o : 1'b1;

   modport core (
      output req_n, frame_n_o, frame_oe, req64_n_o, irdy_n_o, irdy_oe,
      output ad_o, ad_oe, cbe_o, par_o, par_oe,
      input gnt_n, trdy_n, devsel_n, ack64_n, frame_n, irdy_n,
      input local_request_narrow_n, local_request_wide_n,
      output local_grant_n, local_master_phase, local_end_cause,
      output burst_remaining_count, local_word_taken_n,
      output local_low_word_taken_n, local_high_word_taken_n,
      input burst_length_in, local_write_ready_n,
      input local_byte_enables_in, local_ad_in
   );
   modport far (
      input req_n, frame_n, irdy_n, req64_n, ad_o, ad_oe, cbe_o,
      output gnt_n, trdy_n, devsel_n, ack64_n,
      output local_request_narrow_n, local_request_wide_n,
      input local_grant_n, local_master_phase, local_end_cause,
      input burst_remaining_count, local_word_taken_n,
      input local_low_word_taken_n, local_high_word_taken_n,
      output burst_length_in, local_write_ready_n,
      output local_byte_enables_in, local_ad_in
   );
endinterface : pmb_if

// *** core/pmb_pkg.sv ***
// Shared constants for the PCI master burst / back-to-back pair.
// Assumes both ends run on one PCI clock.
package pmb_pkg;
   // Local master phase codes
   localparam logic [3:0] PH_IDLE = 4'h0;
   localparam logic [3:0] PH_ALOAD = 4'h1;
   localparam logic [3:0] PH_TRANS = 4'h2;
   localparam logic [3:0] PH_TERM = 4'h3;
   // End cause codes
   localparam logic [1:0] END_NONE = 2'h0;
   localparam logic [1:0] END_NORMAL = 2'h1;
   localparam int BURST_W = 8;
   // APB register offsets of the far end
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_LEN = 8'h08;
   localparam logic [7:0] REG_DLO = 8'h0C;
   localparam logic [7:0] REG_DHI = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;
   // Field positions
   localparam int CTRL_GO = 0;
   localparam int CTRL_WIDE = 1;
   localparam int CTRL_TXN_LSB = 4;
   localparam int LEN_CMD_LSB = 16;
   localparam int STAT_CAUSE_LSB = 4;
   localparam int STAT_BUSY = 8;
   localparam int STAT_RX_LSB = 16;
   localparam logic [3:0] CMD_RST = 4'h7;
endpackage : pmb_pkg
